// ==== afe_cfg.svh ====
// Purpose: Offsets, field positions, reset values for the AFE output, offset and gain registers.
// Assumes: Register indices are 6-bit addresses on the plain register port.
// Notes:   Definitions only.
`ifndef AFE_CFG_SVH
`define AFE_CFG_SVH

`define AFE_ADDR_W        6
`define AFE_SETUP4_ADDR   6'h05
`define AFE_COARSE_ADDR   6'h06
`define AFE_REV_ADDR      6'h07
`define AFE_DAC_BASE      4'h8
`define AFE_PGA_BASE      4'hA
`define AFE_SETUP4_RST    8'h00
`define AFE_SETUP4_MASK   8'hC0
`define AFE_COARSE_RST    8'h1B
`define AFE_COARSE_MASK   8'h7F
`define AFE_DAC_RST       8'h80
`define AFE_PGA_RST       6'h00
// Arbitrary neutral revision value.
`define AFE_REV_VALUE     8'h52
`define AFE_MUX_BIT       6
`define AFE_INV_BIT       7
`define AFE_HIZ_BIT       4
`define AFE_NCHAN         3

`endif

// ==== afe_pkg.sv ====
// Purpose: Types shared by the AFE register bank files.
// Assumes: None.
// Notes:   Constants live in afe_cfg.svh.
`default_nettype none
package afe_pkg;
    typedef enum logic [1:0] {
        AFE_SIG_BIPOLAR_A = 2'h0,
        AFE_SIG_BIPOLAR_B = 2'h1,
        AFE_SIG_NEGATIVE  = 2'h2,
        AFE_SIG_RESERVED  = 2'h3
    } afe_sig_e;
    typedef enum logic [1:0] {
        AFE_PH_LOW  = 2'b01,
        AFE_PH_HIGH = 2'b10
    } afe_phase_e;
    typedef logic [11:0] afe_code_t;
endpackage
`default_nettype wire

// ==== afe_fmt_if.sv ====
// Purpose: Carries output-format controls and the sample path into the formatter.
// Assumes: One clock.
// Notes:   None.
`default_nettype none
interface afe_fmt_if;
    import afe_pkg::*;
    logic      mux_sel;
    logic      invert;
    logic      in_valid;
    afe_code_t in_code;
    modport ctl (output mux_sel, output invert, output in_valid, output in_code);
    modport fmt (input mux_sel, input invert, input in_valid, input in_code);
endinterface
`default_nettype wire

// ==== afe_out_fmt.sv ====
// Purpose: Inverts and formats each conversion result onto the data bus.
// Assumes: A new sample comes no faster than every second cycle in multiplexed mode.
// Notes:   Multiplexed mode sends the high eight bits first, then the low four bits.
`default_nettype none
module afe_out_fmt
    import afe_pkg::*;
(
    input  wire logic  i_clk,
    input  wire logic  i_sys_rst,
    afe_fmt_if.fmt     f,
    output logic [11:0] o_data,
    output logic        o_data_valid,
    output logic        o_high_phase
);
    typedef struct packed {
        logic [11:0] data;
        logic        valid;
        afe_phase_e  phase;
        logic [3:0]  low_nib;
        logic        pend;
    } afe_fmt_s;

    afe_fmt_s st;
    afe_fmt_s next_st;
    afe_code_t cooked;

    always_comb begin
        cooked = f.invert ? ~f.in_code : f.in_code;
        next_st = st;
        next_st.valid = 1'b0;
        if (f.mux_sel && st.pend) begin
            next_st.data  = {4'h0, st.low_nib, 4'h0};
            next_st.valid = 1'b1;
            next_st.phase = AFE_PH_LOW;
            next_st.pend  = 1'b0;
        end else if (f.in_valid) begin
            next_st.valid = 1'b1;
            if (f.mux_sel) begin
                next_st.data    = {4'h0, cooked[11:4]};
                next_st.phase   = AFE_PH_HIGH;
                next_st.low_nib = cooked[3:0];
                next_st.pend    = 1'b1;
            end else begin
                next_st.data  = cooked;
                next_st.phase = AFE_PH_LOW;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st <= '{data: 12'h000, valid: 1'b0, phase: AFE_PH_LOW, low_nib: 4'h0, pend: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign o_data       = st.data;
    assign o_data_valid = st.valid;
    assign o_high_phase = (st.phase == AFE_PH_HIGH);

    parallel_word_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (f.in_valid && !f.mux_sel && !st.pend) |=> (o_data_valid
        && o_data == ($past(f.invert) ? ~$past(f.in_code) : $past(f.in_code))))
        else $error("Parallel word mismatch.");
    mux_second_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (f.in_valid && f.mux_sel && !st.pend) |=> o_high_phase ##1 (o_data_valid
        && !o_high_phase))
        else $error("Multiplexed low half missing.");
    invert_path_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (f.in_valid && f.invert && !f.mux_sel && !st.pend) |=>
        (o_data == ~$past(f.in_code)))
        else $error("Inversion not applied.");
    mux_cov_c: cover property (@(posedge i_clk) disable iff (i_sys_rst)
        f.in_valid && f.mux_sel ##2 o_data_valid);
    inv_cov_c: cover property (@(posedge i_clk) disable iff (i_sys_rst)
        f.in_valid && f.invert);
endmodule
`default_nettype wire

// ==== afe_chan_bank.sv ====
// Purpose: Per-channel offset DAC and gain codes.
// Assumes: Channel index three is unmapped.
// Notes:   Storage is one flop bank per channel.
`default_nettype none
`include "afe_cfg.svh"
module afe_chan_bank
    import afe_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_wr_dac,
    input  wire logic        i_wr_pga,
    input  wire logic [1:0]  i_chan,
    input  wire logic [7:0]  i_wdata,
    output logic [23:0]      o_dac,
    output logic [17:0]      o_pga
);
    typedef struct packed {
        logic [2:0][7:0] dac;
        logic [2:0][5:0] pga;
    } afe_bank_s;

    afe_bank_s st;
    afe_bank_s next_st;

    always_comb begin
        next_st = st;
        for (int c = 0; c < `AFE_NCHAN; c++) begin
            if (i_wr_dac && i_chan == 2'(c)) next_st.dac[c] = i_wdata;
            if (i_wr_pga && i_chan == 2'(c)) next_st.pga[c] = i_wdata[5:0];
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st <= '{dac: {3{`AFE_DAC_RST}}, pga: {3{`AFE_PGA_RST}}};
        end else begin
            st <= next_st;
        end
    end

    assign o_dac = st.dac;
    assign o_pga = st.pga;

    dac_write_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_wr_dac && i_chan == 2'd1) |=> (o_dac[15:8] == $past(i_wdata)))
        else $error("Offset code not stored.");
    pga_write_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_wr_pga && i_chan == 2'd2) |=> (o_pga[17:12] == $past(i_wdata[5:0])))
        else $error("Gain code not stored.");
endmodule
`default_nettype wire

// ==== afe_output_offset_gain_regs.sv ====
// Purpose: Output format, reference DAC, signal type, revision and channel trim registers.
// Assumes: Plain register port; read data valid one cycle after the read strobe.
// Notes:   Analogue blocks take the codes from the outputs below.
// ****************************************************************************
// Overview of operation
// - Output-mux bit 6 picks a 12-bit parallel word when 0 or two 8-bit transfers when 1.
// - Output-invert bit 7 digitally inverts every output code when set.
// - The low four bits of the coarse-offset register drive the reference DAC, reset 1011.
// - Bit 4 of the coarse-offset register, reset 1, powers down and floats the reference DAC.
// - Bits 6 and 5 select bipolar video for codes 00 and 01 and negative video for 10.
// - Address 000111 is a read-only 8-bit register giving a character for the revision.
// - Address group 1000xy holds one 8-bit offset DAC code per colour channel.
// - Offset code 00 is -200mV, FF is +200mV and reset code 80 is about zero.
// - Address group 1010xy holds one 6-bit gain code per channel, reset zero.
// ****************************************************************************
`default_nettype none
`include "afe_cfg.svh"
module afe_output_offset_gain_regs
    import afe_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic [5:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic [7:0]       o_rdata,
    input  wire logic        i_adc_valid,
    input  wire logic [11:0] i_adc_code,
    output logic [11:0]      o_data,
    output logic             o_data_valid,
    output logic             o_high_phase,
    output logic [3:0]       o_ref_level_code,
    output logic             o_ref_level_pin_oe,
    output logic             o_ref_dac_power,
    output logic [1:0]       o_adc_input_signal_type,
    output logic             o_negative_video,
    output logic [23:0]      o_offset_dac,
    output logic [17:0]      o_gain
);
    // ************************************************************************
    // Register state
    // ************************************************************************
    typedef struct packed {
        logic [7:0] setup4;
        logic [7:0] coarse;
        logic [7:0] rdata;
    } afe_regs_s;

    afe_regs_s st;
    afe_regs_s next_st;
    logic      dac_hit;
    logic      pga_hit;
    logic [23:0] dac_all;
    logic [17:0] pga_all;
    logic [7:0]  rd_mux;

    assign dac_hit = (i_addr[5:2] == `AFE_DAC_BASE);
    assign pga_hit = (i_addr[5:2] == `AFE_PGA_BASE);

    always_comb begin
        rd_mux = 8'h00;
        if (i_addr == `AFE_SETUP4_ADDR) begin
            rd_mux = st.setup4;
        end else if (i_addr == `AFE_COARSE_ADDR) begin
            rd_mux = st.coarse;
        end else if (i_addr == `AFE_REV_ADDR) begin
            rd_mux = `AFE_REV_VALUE;
        end else if (dac_hit && i_addr[1:0] != 2'h3) begin
            rd_mux = dac_all[8*i_addr[1:0] +: 8];
        end else if (pga_hit && i_addr[1:0] != 2'h3) begin
            rd_mux = {2'b00, pga_all[6*i_addr[1:0] +: 6]};
        end
    end

    always_comb begin
        next_st = st;
        next_st.rdata = i_rd ? rd_mux : 8'h00;
        if (i_wr && i_addr == `AFE_SETUP4_ADDR) begin
            next_st.setup4 = i_wdata & `AFE_SETUP4_MASK;
        end
        // Writes to the revision address are ignored so the value stays fixed.
        if (i_wr && i_addr == `AFE_COARSE_ADDR) begin
            next_st.coarse = i_wdata & `AFE_COARSE_MASK;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st <= '{setup4: `AFE_SETUP4_RST, coarse: `AFE_COARSE_RST, rdata: 8'h00};
        end else begin
            st <= next_st;
        end
    end

    assign o_rdata = st.rdata;

    // ************************************************************************
    // Reference DAC and converter input
    // ************************************************************************
    assign o_ref_level_code   = st.coarse[3:0];
    // The pin is left floating when the DAC is powered down so a board can drive it.
    assign o_ref_level_pin_oe = ~st.coarse[`AFE_HIZ_BIT];
    assign o_ref_dac_power    = ~st.coarse[`AFE_HIZ_BIT];
    assign o_adc_input_signal_type = st.coarse[6:5];
    // Code 11 is reserved; it is decoded as bipolar to stay harmless.
    assign o_negative_video = (afe_sig_e'(st.coarse[6:5]) == AFE_SIG_NEGATIVE);

    // ************************************************************************
    // Channel trims and output formatter
    // ************************************************************************
    afe_chan_bank u_bank (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_wr_dac  (i_wr && dac_hit),
        .i_wr_pga  (i_wr && pga_hit),
        .i_chan    (i_addr[1:0]),
        .i_wdata   (i_wdata),
        .o_dac     (dac_all),
        .o_pga     (pga_all)
    );
    assign o_offset_dac = dac_all;
    assign o_gain       = pga_all;

    afe_fmt_if fif ();
    assign fif.mux_sel  = st.setup4[`AFE_MUX_BIT];
    assign fif.invert   = st.setup4[`AFE_INV_BIT];
    assign fif.in_valid = i_adc_valid;
    assign fif.in_code  = i_adc_code;

    afe_out_fmt u_fmt (
        .i_clk        (i_clk),
        .i_sys_rst    (i_sys_rst),
        .f            (fif),
        .o_data       (o_data),
        .o_data_valid (o_data_valid),
        .o_high_phase (o_high_phase)
    );

    // ************************************************************************
    // Checks
    // ************************************************************************
    rev_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_rd && i_addr == `AFE_REV_ADDR) |=> (o_rdata == `AFE_REV_VALUE))
        else $error("Revision read wrong.");
    ref_code_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_wr && i_addr == `AFE_COARSE_ADDR) |=> (o_ref_level_code == $past(i_wdata[3:0])))
        else $error("Reference code not applied.");
    ref_hiz_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_wr && i_addr == `AFE_COARSE_ADDR) |=> (o_ref_level_pin_oe == !$past(i_wdata[4])))
        else $error("Reference drive wrong.");
    sig_type_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_wr && i_addr == `AFE_COARSE_ADDR && i_wdata[6:5] == 2'b10) |=> o_negative_video)
        else $error("Negative video not selected.");
    dac_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_rd && i_addr == 6'h20) |=> (o_rdata == $past(o_offset_dac[7:0])))
        else $error("Offset readback wrong.");
    gain_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_rd && i_addr == 6'h29) |=> (o_rdata == {2'b00, $past(o_gain[11:6])}))
        else $error("Gain readback wrong.");
    rev_cov_c: cover property (@(posedge i_clk) disable iff (i_sys_rst)
        i_rd && i_addr == `AFE_REV_ADDR);
    ext_cov_c: cover property (@(posedge i_clk) disable iff (i_sys_rst)
        o_ref_level_pin_oe);
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the AFE output, offset and gain register bank.
// Assumes: Register port answers reads one cycle later; writes show on outputs one cycle later.
// Notes:   Stimulus is driven by non-blocking assignment just after each rising edge.
`default_nettype none
`include "afe_cfg.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import afe_pkg::*;
    logic        i_clk;
    logic        i_sys_rst;
    logic [5:0]  i_addr;
    logic [7:0]  i_wdata;
    logic        i_wr;
    logic        i_rd;
    logic [7:0]  o_rdata;
    logic        i_adc_valid;
    logic [11:0] i_adc_code;
    logic [11:0] o_data;
    logic        o_data_valid;
    logic        o_high_phase;
    logic [3:0]  o_ref_level_code;
    logic        o_ref_level_pin_oe;
    logic        o_ref_dac_power;
    logic [1:0]  o_adc_input_signal_type;
    logic        o_negative_video;
    logic [23:0] o_offset_dac;
    logic [17:0] o_gain;
    int          bad_count;
    int          n_checks;

    afe_output_offset_gain_regs uut (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_adc_valid(i_adc_valid),
        .i_adc_code(i_adc_code), .o_data(o_data), .o_data_valid(o_data_valid),
        .o_high_phase(o_high_phase), .o_ref_level_code(o_ref_level_code),
        .o_ref_level_pin_oe(o_ref_level_pin_oe), .o_ref_dac_power(o_ref_dac_power),
        .o_adc_input_signal_type(o_adc_input_signal_type),
        .o_negative_video(o_negative_video), .o_offset_dac(o_offset_dac), .o_gain(o_gain)
    );

    always #10 i_clk = ~i_clk;

    // ************************************************************************
    // Shared tasks
    // ************************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr    <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe, so it is sampled there.
    task automatic reg_rd_chk(input logic [5:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd   <= 1'b0;
        #1;
        chk(32'(o_rdata), 32'(exp));
    endtask

    task automatic sample(input logic [11:0] c);
        @(posedge i_clk);
        i_adc_valid <= 1'b1;
        i_adc_code  <= c;
        @(posedge i_clk);
        i_adc_valid <= 1'b0;
        #1;
    endtask

    // ************************************************************************
    // Scenarios
    // ************************************************************************
    task automatic t_reset_values();
        chk(32'(o_ref_level_code), 32'h0000_000B);
        chk(32'({o_ref_level_pin_oe, o_ref_dac_power}), 32'h0000_0000);
        chk(32'(o_offset_dac), 32'h0080_8080);
        chk(32'(o_gain), 32'h0000_0000);
        chk(32'({o_data_valid, o_high_phase, o_data}), 32'h0000_0000);
        reg_rd_chk(`AFE_COARSE_ADDR, 8'h1B);
        reg_rd_chk(`AFE_SETUP4_ADDR, 8'h00);
        reg_rd_chk(`AFE_REV_ADDR, `AFE_REV_VALUE);
    endtask

    task automatic t_read_only_and_unmapped();
        reg_wr(`AFE_REV_ADDR, 8'h00);
        reg_rd_chk(`AFE_REV_ADDR, `AFE_REV_VALUE);
        reg_rd_chk(6'h23, 8'h00);
        reg_rd_chk(6'h3F, 8'h00);
    endtask

    // The reserved signal-type code is never written, so only the three legal codes are set.
    task automatic t_coarse_fields();
        logic [1:0] st;
        for (int i = 0; i < 3; i++) begin
            st = 2'(i);
            reg_wr(`AFE_COARSE_ADDR, {1'b0, st, 1'b0, 4'(i + 3)});
            chk(32'(o_adc_input_signal_type), 32'(st));
            chk(32'(o_negative_video), 32'(st == 2'h2));
            chk(32'(o_ref_level_code), 32'(i + 3));
            chk(32'({o_ref_level_pin_oe, o_ref_dac_power}), 32'h0000_0003);
        end
        reg_wr(`AFE_COARSE_ADDR, 8'hDF);
        chk(32'({o_ref_level_pin_oe, o_ref_dac_power}), 32'h0000_0000);
        reg_rd_chk(`AFE_COARSE_ADDR, 8'h5F);
    endtask

    task automatic t_channels();
        reg_wr(6'h20, 8'h00);
        reg_wr(6'h21, 8'hFF);
        reg_wr(6'h22, 8'h5A);
        reg_wr(6'h28, 8'hFF);
        reg_wr(6'h29, 8'h3F);
        reg_wr(6'h2A, 8'h15);
        chk(32'(o_offset_dac), 32'h005A_FF00);
        chk(32'(o_gain), 32'({6'h15, 6'h3F, 6'h3F}));
        reg_rd_chk(6'h21, 8'hFF);
        reg_rd_chk(6'h28, 8'h3F);
        reg_rd_chk(6'h2A, 8'h15);
    endtask

    task automatic t_parallel_invert();
        reg_wr(`AFE_SETUP4_ADDR, 8'h00);
        sample(12'hA53);
        chk(32'({o_data_valid, o_data}), 32'h0000_1A53);
        reg_wr(`AFE_SETUP4_ADDR, 8'h80);
        sample(12'hA53);
        chk(32'({o_data_valid, o_data}), 32'h0000_15AC);
        reg_rd_chk(`AFE_SETUP4_ADDR, 8'h80);
    endtask

    task automatic t_mux();
        reg_wr(`AFE_SETUP4_ADDR, 8'hFF);
        reg_rd_chk(`AFE_SETUP4_ADDR, 8'hC0);
        sample(12'h3C9);
        chk(32'({o_data_valid, o_high_phase, o_data[7:0]}), 32'h0000_03C3);
        @(posedge i_clk);
        #1;
        chk(32'({o_data_valid, o_high_phase, o_data[7:4]}), 32'h0000_0026);
        reg_wr(`AFE_SETUP4_ADDR, 8'h40);
        sample(12'h3C9);
        chk(32'({o_data_valid, o_high_phase, o_data[7:0]}), 32'h0000_033C);
        @(posedge i_clk);
        #1;
        chk(32'({o_data_valid, o_high_phase, o_data[7:4]}), 32'h0000_0029);
    endtask

    initial begin
        #200_000;
        bad_count++;
        results();
    end

    initial begin
        i_clk       = 1'b0;
        i_sys_rst   = 1'b1;
        i_addr      = 6'h00;
        i_wdata     = 8'h00;
        i_wr        = 1'b0;
        i_rd        = 1'b0;
        i_adc_valid = 1'b0;
        i_adc_code  = 12'h000;
        bad_count   = 0;
        n_checks    = 0;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        #1;
        t_reset_values();
        t_read_only_and_unmapped();
        t_coarse_fields();
        t_channels();
        t_parallel_invert();
        t_mux();
        // A second reset in mid-run must bring every register back to its default.
        @(posedge i_clk);
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        #1;
        t_reset_values();
        results();
    end
endmodule
`default_nettype wire
